// [core/dpw_merge.v]
`timescale 1ns/1ps
module dpw_merge #(
  parameter AW = 32
) (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire ce_i,
  input wire merge_dis_i,
  input wire req_valid_i,
  input wire [AW-1:0] req_addr_i,
  output wire req_ready_o,
  output reg out_valid_o,
  output reg [AW-1:0] out_addr_o,
  output reg out_four_o,
  input wire out_ready_i
);
  // ==========
  // one 2QW request held waiting for its linear partner
  reg hold_reg;
  reg [AW-1:0] hold_addr_reg;
  wire out_free;
  wire linear;
  assign out_free = !out_valid_o || out_ready_i;
  assign linear = (req_addr_i == hold_addr_reg + 16);
  assign req_ready_o = out_free;
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      hold_reg <= 1'b0;
      hold_addr_reg <= {AW{1'b0}};
      out_valid_o <= 1'b0;
      out_addr_o <= {AW{1'b0}};
      out_four_o <= 1'b0;
    end else if (ce_i) begin
      if (out_valid_o && out_ready_i)
        out_valid_o <= 1'b0;
      if (out_free) begin
        if (req_valid_i) begin
          if (merge_dis_i) begin
            if (hold_reg) begin
              out_valid_o <= 1'b1;
              out_addr_o <= hold_addr_reg;
              out_four_o <= 1'b0;
              hold_addr_reg <= req_addr_i;
            end else begin
              out_valid_o <= 1'b1;
              out_addr_o <= req_addr_i;
              out_four_o <= 1'b0;
            end
          end else if (hold_reg && linear) begin
            out_valid_o <= 1'b1;
            out_addr_o <= hold_addr_reg;
            out_four_o <= 1'b1;
            hold_reg <= 1'b0;
          end else if (hold_reg) begin
            out_valid_o <= 1'b1;
            out_addr_o <= hold_addr_reg;
            out_four_o <= 1'b0;
            hold_addr_reg <= req_addr_i;
          end else begin
            hold_reg <= 1'b1;
            hold_addr_reg <= req_addr_i;
          end
        end else if (hold_reg) begin
          // no partner this cycle: flush rather than stall the client
          out_valid_o <= 1'b1;
          out_addr_o <= hold_addr_reg;
          out_four_o <= 1'b0;
          hold_reg <= 1'b0;
        end
      end
    end
  end
endmodule // dpw_merge

// [core/dpw_regs.vh]
// Functional notes
// - column type: nine or ten column bits
// - unused pad field powers down address bits
// - code 01 enters debug mode, strobes off
// - data-mask pads powered down when set
// - capture codes: rising low half, falling high
// - override lets S3 request self-refresh despite snapshot
// - merge two 2QW linear requests unless disabled
// - tri-state outputs in self-refresh, precharge down
// - tri-state outputs during active power-down
`ifndef DPW_REGS_VH
`define DPW_REGS_VH
// ==========
// register offsets
`define DPW_PAD_OFS 8'hDD
`define DPW_MRG_OFS 8'hDE
`define DPW_WCT_OFS 8'hDF
// ==========
// field positions
`define DPW_PAD_ODT 7
`define DPW_PAD_COL 6
`define DPW_PAD_MA_HI 5
`define DPW_PAD_MA_LO 4
`define DPW_PAD_DM 3
`define DPW_PAD_CAP_HI 2
`define DPW_MRG_S3 2
`define DPW_MRG_DIS 1
`define DPW_MRG_MASK 8'h06
`define DPW_WCT_WL_HI 7
`define DPW_WCT_WL_LO 6
`define DPW_WCT_PDTS 5
`define DPW_WCT_WD_HI 4
`define DPW_WCT_WD_LO 3
`define DPW_WCT_APTS 2
`define DPW_WCT_CK_HI 1
`define DPW_RST_VAL 8'h00
`endif

// [core/dpw_top.v]
`timescale 1ns/1ps
`include "dpw_regs.vh"
module dpw_top #(
  parameter AW = 32
) (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire ce_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire [9:0] col_addr_i,
  output wire [9:0] col_addr_o,
  input wire [12:0] addr_pins_i,
  output wire [12:0] addr_pins_o,
  output wire [12:0] addr_pins_oe_o,
  output wire [3:0] strobe_oe_o,
  output wire debug_mode_o,
  input wire [1:0] dm_i,
  output wire [1:0] dm_o,
  output wire [1:0] dm_oe_o,
  output wire odt_pad_pd_o,
  output wire capture_falling_o,
  output wire [1:0] capture_delay_o,
  input wire snapshot_req_i,
  input wire s3_req_i,
  output wire self_refresh_req_o,
  output wire [1:0] write_latency_o,
  output wire [1:0] write_dqs_delay_o,
  output wire [1:0] mclk_delay_o,
  input wire st_self_refresh_i,
  input wire st_precharge_pd_i,
  input wire st_active_pd_i,
  output wire float_cmd_o,
  output wire float_cke_o,
  output wire float_odt_o,
  output wire float_mclk_o,
  input wire grq_valid_i,
  input wire [AW-1:0] grq_addr_i,
  output wire grq_ready_o,
  output wire mif_valid_o,
  output wire [AW-1:0] mif_addr_o,
  output wire mif_four_o,
  input wire mif_ready_i
);
  // ==========
  // registers
  reg [7:0] pad_reg;
  reg [7:0] mrg_reg;
  reg [7:0] wct_reg;
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pad_reg <= `DPW_RST_VAL;
      mrg_reg <= `DPW_RST_VAL;
      wct_reg <= `DPW_RST_VAL;
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `DPW_PAD_OFS: pad_reg <= reg_wdata_i;
          `DPW_MRG_OFS: mrg_reg <= reg_wdata_i & `DPW_MRG_MASK;
          `DPW_WCT_OFS: wct_reg <= reg_wdata_i;
          default: ;
        endcase
      end
      if (reg_rd_i) begin
        case (reg_addr_i)
          `DPW_PAD_OFS: reg_rdata_o <= pad_reg;
          `DPW_MRG_OFS: reg_rdata_o <= mrg_reg;
          `DPW_WCT_OFS: reg_rdata_o <= wct_reg;
          default: reg_rdata_o <= 8'h00;
        endcase
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end
  // ==========
  // pad control
  wire [1:0] ma_sel;
  wire dbg;
  wire float_all;
  wire float_most;
  assign ma_sel = pad_reg[`DPW_PAD_MA_HI:`DPW_PAD_MA_LO];
  assign dbg = (ma_sel == 2'b01);
  assign debug_mode_o = dbg;
  // nine-bit mode forces bit 9 low so the DRAM never sees stray column bits
  assign col_addr_o = pad_reg[`DPW_PAD_COL] ? col_addr_i : {1'b0, col_addr_i[8:0]};
  assign float_all = wct_reg[`DPW_WCT_PDTS] && st_self_refresh_i;
  assign float_most = (wct_reg[`DPW_WCT_PDTS] && st_precharge_pd_i) ||
    (wct_reg[`DPW_WCT_APTS] && st_active_pd_i);
  assign float_cmd_o = float_all || float_most;
  assign float_cke_o = 1'b0;
  assign float_odt_o = float_all;
  assign float_mclk_o = float_all;
  assign addr_pins_o = addr_pins_i;
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_ma
      assign addr_pins_oe_o[gi] = !float_cmd_o;
    end
  endgenerate
  assign addr_pins_oe_o[12] = !float_cmd_o && (ma_sel == 2'b00);
  assign addr_pins_oe_o[11] = !float_cmd_o && !ma_sel[0];
  assign strobe_oe_o = (dbg || float_cmd_o) ? 4'h0 : 4'hF;
  assign dm_o = pad_reg[`DPW_PAD_DM] ? 2'b00 : dm_i;
  assign dm_oe_o = (pad_reg[`DPW_PAD_DM] || float_cmd_o) ? 2'b00 : 2'b11;
  assign odt_pad_pd_o = pad_reg[`DPW_PAD_ODT];
  assign capture_falling_o = pad_reg[`DPW_PAD_CAP_HI];
  assign capture_delay_o = pad_reg[1:0];
  // ==========
  // sleep and timing
  // snapshot blocks self-refresh unless overridden
  assign self_refresh_req_o = s3_req_i && (!snapshot_req_i || mrg_reg[`DPW_MRG_S3]);
  assign write_latency_o = wct_reg[`DPW_WCT_WL_HI:`DPW_WCT_WL_LO];
  assign write_dqs_delay_o = wct_reg[`DPW_WCT_WD_HI:`DPW_WCT_WD_LO];
  assign mclk_delay_o = wct_reg[`DPW_WCT_CK_HI:0];
  // ==========
  // graphics merge
  dpw_merge #(.AW(AW)) u_merge (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .merge_dis_i(mrg_reg[`DPW_MRG_DIS]),
    .req_valid_i(grq_valid_i),
    .req_addr_i(grq_addr_i),
    .req_ready_o(grq_ready_o),
    .out_valid_o(mif_valid_o),
    .out_addr_o(mif_addr_o),
    .out_four_o(mif_four_o),
    .out_ready_i(mif_ready_i)
  );
endmodule // dpw_top

// [testbench/dpw_sink.sv]
`timescale 1ns/1ps
// ====
// request sink
module dpw_sink (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire valid_i,
  output reg ready_o = 1'b0
);
  // stalls every other beat so held requests must wait
  always @(posedge clk_sys_i) begin
    ready_o <= nrst_i & valid_i & ~ready_o;
  end
endmodule // dpw_sink

// [testbench/dpw_top_asserts.sv]
`timescale 1ns/1ps
// ====
// port checks
module dpw_chk #(
  parameter AW = 32
) (
  input wire clk_sys_i,
  input wire nrst_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire [12:0] addr_pins_oe_o,
  input wire [3:0] strobe_oe_o,
  input wire debug_mode_o,
  input wire st_self_refresh_i,
  input wire float_cmd_o,
  input wire float_cke_o,
  input wire float_odt_o,
  input wire float_mclk_o,
  input wire grq_ready_o,
  input wire mif_valid_o,
  input wire [AW-1:0] mif_addr_o,
  input wire mif_ready_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  property p_pad; addr_pins_oe_o[12] |-> addr_pins_oe_o[11]; endproperty
  a_pad: assert property (p_pad) else $error("pad");
  property p_dbg; debug_mode_o |-> !(|strobe_oe_o) && !(|addr_pins_oe_o[12:11]); endproperty
  a_dbg: assert property (p_dbg) else $error("dbg");
  property p_cke; !float_cke_o; endproperty
  a_cke: assert property (p_cke) else $error("cke");
  property p_mck; float_mclk_o |-> st_self_refresh_i && float_odt_o; endproperty
  a_mck: assert property (p_mck) else $error("mclk");
  property p_odt; float_odt_o |-> float_cmd_o && float_mclk_o; endproperty
  a_odt: assert property (p_odt) else $error("odt");
  property p_hld; mif_valid_o && !mif_ready_i |=> mif_valid_o && $stable(mif_addr_o); endproperty
  a_hld: assert property (p_hld) else $error("hold");
  property p_rdy; mif_valid_o && !mif_ready_i |-> !grq_ready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  property p_rd; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("rdata");
  c_mif: cover property (mif_valid_o && mif_ready_i);
  c_dbg: cover property (debug_mode_o);
  c_flt: cover property (float_mclk_o);
endmodule // dpw_chk
bind dpw_top dpw_chk #(.AW(AW)) dpw_chk_i (.*);

// [testbench/test_dpw_top.sv]
`timescale 1ns/1ps
`include "dpw_regs.vh"
// ====
// bench
module test_dpw_top;
  reg clk_sys_i = 1'b0;
  reg nrst_i = 1'b0;
  reg wr = 1'b0, rd = 1'b0, s3 = 1'b0, gv = 1'b0;
  reg [2:0] st = 3'h0;
  reg [7:0] ad = 8'h00, wd = 8'h00, m_rd;
  reg [31:0] ga = 32'h0, m_a;
  reg m_f;
  integer n_fail = 0, tests_run = 0, n_mif = 0, n0, i;
  wire [7:0] rdat;
  wire [9:0] col;
  wire [12:0] oe;
  wire [3:0] so;
  wire [1:0] dmo, dmoe, cdl, wl, wdq, mck;
  wire [31:0] ma;
  wire dbg, cf, srq, fc, fk, fo, fm, grdy, mv, m4, mr;
  initial forever #5 clk_sys_i = ~clk_sys_i;
  dpw_top dpw_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .col_addr_i(10'h3FF),
    .col_addr_o(col), .addr_pins_i(13'h0), .addr_pins_o(), .addr_pins_oe_o(oe),
    .strobe_oe_o(so), .debug_mode_o(dbg), .dm_i(2'h3), .dm_o(dmo), .dm_oe_o(dmoe),
    .odt_pad_pd_o(), .capture_falling_o(cf), .capture_delay_o(cdl), .snapshot_req_i(1'b1),
    .s3_req_i(s3), .self_refresh_req_o(srq), .write_latency_o(wl), .write_dqs_delay_o(wdq),
    .mclk_delay_o(mck), .st_self_refresh_i(st[2]), .st_precharge_pd_i(st[1]),
    .st_active_pd_i(st[0]), .float_cmd_o(fc), .float_cke_o(fk), .float_odt_o(fo),
    .float_mclk_o(fm), .grq_valid_i(gv), .grq_addr_i(ga), .grq_ready_o(grdy),
    .mif_valid_o(mv), .mif_addr_o(ma), .mif_four_o(m4), .mif_ready_i(mr));
  dpw_sink dpw_sink_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .valid_i(mv), .ready_o(mr));
  always @(posedge clk_sys_i) begin
    if (mv && mr) begin
      n_mif <= n_mif + 1;
      m_a <= ma;
      m_f <= m4;
    end
  end
  // wide enough for the merge flag beside the full address
  task chk(input [8*5:1] nm, input [39:0] got, input [39:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s exp %0h got %0h", nm, exp, got);
      end
    end
  endtask
  // entered one ns after an edge except from t_mrg(1'b1), which enters on the edge; strobes use nonblocking writes
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      ad <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk_sys_i);
      #1 m_rd = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task t_reg;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        acc(1'b0, 8'(8'hDC + i), 8'h00);
        chk("rst", m_rd, 8'h00);
        acc(1'b1, 8'(8'hDC + i), 8'hFF);
        acc(1'b0, 8'(8'hDC + i), 8'h00);
        chk("rdbk", m_rd, i == 0 ? 8'h00 : i == 2 ? `DPW_MRG_MASK : 8'hFF);
      end
      $display("regs done");
    end
  endtask
  task t_pad;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        acc(1'b1, `DPW_PAD_OFS, {1'b0, i[2], i[1:0], i[2], i[2:0]});
        chk("col", col, {i[2], 9'h1FF});
        chk("oe", {dbg, so, oe[12:11]}, {i[1:0] == 1, i[1:0] == 1 ? 4'h0 : 4'hF, i[1:0] == 0, !i[0]});
        chk("dm", {dmo, dmoe}, i[2] ? 4'h0 : 4'hF);
        chk("cap", {cf, cdl}, i[2:0]);
      end
      $display("pads done");
    end
  endtask
  task t_wct;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        acc(1'b1, `DPW_WCT_OFS, {i[1:0], 1'b0, i[1:0], 1'b0, i[1:0]});
        chk("wct", {wl, wdq, mck}, {3{i[1:0]}});
      end
      for (i = 1; i < 9; i = i * 2) begin
        acc(1'b1, `DPW_WCT_OFS, i == 8 ? 8'h20 : 8'h24);
        st <= i == 8 ? 3'h1 : i[2:0];
        acc(1'b0, 8'hDC, 8'h00);
        chk("flt", {fc, fk, fo, fm}, i == 4 ? 4'hB : i == 8 ? 4'h0 : 4'h8);
        st <= 3'h0;
      end
      $display("float done");
    end
  endtask
  task t_mrg(input d);
    begin
      acc(1'b1, `DPW_MRG_OFS, {5'h00, !d, d, 1'b0});
      chk("srq", srq, !d);
      n0 = n_mif;
      gv <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
        ga <= 32'h100 + 16 * i;
        @(negedge clk_sys_i);
        while (!grdy) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
      end
      gv <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      chk("mcnt", n_mif - n0, d ? 2 : 1);
      chk("mmrg", {m_f, m_a}, d ? 33'h110 : 33'h100000100);
      $display("merge done");
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    s3 <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    t_reg;
    t_pad;
    t_wct;
    t_mrg(1'b0);
    t_mrg(1'b1);
    test_done;
  end
  initial begin
    #20000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule // test_dpw_top
